// [rtl/uug_ctrl.sv]
// Strobed register access was decided locally.
`timescale 1ns/100ps
// Summary of operation
// - Half-duplex bit set: receive line ignored while transmitter is busy.
// - Software mode: pause character stops sending, resume character restarts it.
// - Multidrop modes use both character registers as address match values.
// - Wrap bit 2 feeds the transmit output back into the receiver.
// - Fault bit 3 latches on break, cleared by reading the fault register.
// - Fault bit 4 latches on missing stop bit, cleared by read.
// - Fault bit 5 latches on parity failure, cleared by read.
// - Fault bit 6 latches on byte arriving with receive FIFO full.
// - Fault bit 7 shows live break state, not latched.
// - Non-zero break register holds line low after current character finishes.
// - Direction output released after turnaround bit times once sending ends.
// - Pin function field maps pins to handshake or RS-485 direction use.
// - Function 100 asserts direction only after a multidrop address match.
// - Function bit 3 sets direction polarity during transmission.
// - Direction bits steer general pins only; function pins not reported.
// - Unmasked input pin change raises a notify pulse; masked ones do not.
// - Drive-high writes set outputs, drive-low writes clear; zeros ignored.
// - Level register returns present level of general pins.
// - Wide bit 0, packet size bit 1; class command sets bit 1.
// - Low latency set automatically below 46921 bps; host may set it.
// - Forward at 64 bytes (63 with packet size bit set) or idle timeout, or any data when low latency.
// - Notify enable bits place pin levels in upper notify byte.
// - Flow field selects none, hardware, software or one of two multidrop modes.
module uug_ctrl
  import uug_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  uug_reg_req_t     reg_req,
  output logic [7:0]       reg_rdata,
  input  wire logic        rx_pin,
  input  wire logic        tx_shift,
  input  wire logic        tx_busy,
  input  wire logic        bit_tick,
  input  uug_rx_ev_t       rx_ev,
  input  wire logic        rx_fifo_full,
  input  wire logic        rx_near_full,
  input  wire logic        rx_break_live,
  input  wire logic [9:0]  rx_fifo_count,
  input  wire logic        idle_timeout,
  input  wire logic        bulk_in_req,
  input  wire logic        cdc_cmd,
  input  wire logic        baud_load,
  input  wire logic [23:0] baud_rate,
  input  wire logic [5:0]  general_pin_in,
  output logic [5:0]       general_pin_out,
  output logic [5:0]       general_pin_oe,
  output logic             line_direction_out,
  output logic             rx_line,
  output logic             tx_line,
  output logic             rx_keep,
  output logic             tx_hold,
  output logic             wide_mode,
  output logic             bulk_packet_size_select,
  output logic             forward_now,
  output logic             notify_pulse,
  output logic [7:0]       notify_hi
);
  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  logic [7:0] flow_r, res_r, pause_r, wrap_r, brk_r, turn_r, func_r;
  logic [7:0] wide_r, lat_r, note_r;
  logic [5:0] dir_r, mask_r, pin_drv_r, prev_in_r;
  logic [3:0] flt_r;
  logic       brk_prev_r, paused_r, match_r, brk_act_r;
  logic [3:0] cnt_r;
  logic [7:0] rdata_r, notify_hi_r;
  logic [5:0] gp_out_r, gp_oe_r;
  logic       dir_out_r, rx_line_r, tx_line_r, rx_keep_r, tx_hold_r;
  logic       fwd_r, note_pulse_r;
  uug_dir_st_t dir_st_r, dir_st_nxt;

  wire logic [7:0] wd      = reg_req.wdata;
  wire logic       wr_flow = reg_req.wr & hit(reg_req.addr, OFS_FLOW);
  wire logic       wr_high = reg_req.wr & hit(reg_req.addr, OFS_HIGH);
  wire logic       wr_low  = reg_req.wr & hit(reg_req.addr, OFS_LOW);
  wire logic       wr_wide = reg_req.wr & hit(reg_req.addr, OFS_WIDE);
  wire logic       wr_lat  = reg_req.wr & hit(reg_req.addr, OFS_LAT);
  wire logic       rd_flt  = reg_req.rd & hit(reg_req.addr, OFS_FAULT);

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  wire uug_flow_t fmode = uug_flow_t'(flow_r[2:0]);
  wire uug_pin_t  pmode = uug_pin_t'(func_r[2:0]);
  wire logic hdx   = flow_r[FLOW_HDX];
  wire logic md    = (fmode == FM_MD_RX) | (fmode == FM_MD_ALL);
  wire logic swfc  = fmode == FM_SW;
  wire logic hwfc  = fmode == FM_HW;
  wire logic p485  = (pmode == PM_485) | (pmode == PM_485_ADDR);
  // Function pins are taken away from software direction, drive, level and change notify
  wire logic [5:0] gen = (pmode == PM_RTSCTS) ? GEN_RTSCTS :
                         (pmode == PM_DTRDSR) ? GEN_DTRDSR :
                         p485 ? GEN_485 : GEN_ALL;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flow_r  <= RST_REG;
      res_r   <= RST_REG;
      pause_r <= RST_REG;
      wrap_r  <= RST_REG;
      brk_r   <= RST_REG;
      turn_r  <= RST_REG;
      func_r  <= RST_REG;
      note_r  <= RST_REG;
      dir_r   <= 6'h00;
      mask_r  <= 6'h00;
    end else if (reg_req.wr) begin
      if (wr_flow) flow_r <= wd & MASK_FLOW;
      if (hit(reg_req.addr, OFS_RES)) res_r <= wd;
      if (hit(reg_req.addr, OFS_PAUSE)) pause_r <= wd;
      if (hit(reg_req.addr, OFS_WRAP)) wrap_r <= wd & MASK_WRAP;
      if (hit(reg_req.addr, OFS_BRK)) brk_r <= wd;
      if (hit(reg_req.addr, OFS_TURN)) turn_r <= wd & MASK_TURN;
      if (hit(reg_req.addr, OFS_FUNC)) func_r <= wd & MASK_FUNC;
      if (hit(reg_req.addr, OFS_NOTE)) note_r <= wd & MASK_NOTE;
      if (hit(reg_req.addr, OFS_DIR)) dir_r <= wd[5:0];
      if (hit(reg_req.addr, OFS_MASK)) mask_r <= wd[5:0];
    end
  end

  // Hardware sets win over a software write in the same cycle
  wire logic [7:0] wide_nxt = (wr_wide ? (wd & MASK_WIDE) : wide_r)
                              | {6'h00, cdc_cmd, 1'b0};
  wire logic ll_auto = baud_load & (baud_rate < BAUD_LL_LIMIT);
  wire logic [7:0] lat_nxt  = (wr_lat ? (wd & MASK_LAT) : lat_r)
                              | {7'h00, ll_auto};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wide_r <= RST_REG;
      lat_r  <= RST_REG;
    end else begin
      wide_r <= wide_nxt;
      lat_r  <= lat_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Line faults
  // ---------------------------------------------------------------
  wire logic brk_rise = rx_break_live & ~brk_prev_r;
  wire logic [3:0] flt_set = {rx_ev.valid & rx_fifo_full,
                              rx_ev.valid & rx_ev.parity_err,
                              rx_ev.valid & rx_ev.frame_err,
                              brk_rise};
  // Read clears, but an event in the read cycle survives it
  wire logic [3:0] flt_nxt = (flt_r & {4{~rd_flt}}) | flt_set;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flt_r      <= 4'h0;
      brk_prev_r <= 1'b0;
    end else begin
      flt_r      <= flt_nxt;
      brk_prev_r <= rx_break_live;
    end
  end

  // ---------------------------------------------------------------
  // Flow control and address match
  // ---------------------------------------------------------------
  wire logic is_res   = rx_ev.data == res_r;
  wire logic is_pause = rx_ev.data == pause_r;
  wire logic paused_nxt = ~swfc ? 1'b0 :
                          (rx_ev.valid & is_pause) ? 1'b1 :
                          (rx_ev.valid & is_res) ? 1'b0 : paused_r;
  // Either character register counts as this node's address
  wire logic match_nxt = ~md ? 1'b0 :
                         (rx_ev.valid & rx_ev.addr_flag) ? (is_res | is_pause) :
                         match_r;
  wire logic hw_stop = hwfc & (((pmode == PM_RTSCTS) & general_pin_in[4]) |
                               ((pmode == PM_DTRDSR) & general_pin_in[2]));
  wire logic keep_nxt = rx_ev.valid &
                        (~md | (match_r & ~rx_ev.addr_flag));
  wire logic hold_nxt = paused_r | hw_stop | (brk_r != 8'h00) |
                        ((fmode == FM_MD_ALL) & ~match_r);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      paused_r  <= 1'b0;
      match_r   <= 1'b0;
      rx_keep_r <= 1'b0;
      tx_hold_r <= 1'b0;
    end else begin
      paused_r  <= paused_nxt;
      match_r   <= match_nxt;
      rx_keep_r <= keep_nxt;
      tx_hold_r <= hold_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Break, wrap and half-duplex blanking
  // ---------------------------------------------------------------
  // Break waits until the transmitter has seen the hold, so no byte is cut short
  wire logic brk_act_nxt = (brk_r == 8'h00) ? 1'b0 :
                           (~tx_busy & tx_hold_r) ? 1'b1 : brk_act_r;
  wire logic tx_line_nxt = brk_act_r ? 1'b0 : tx_shift;
  wire logic rx_line_nxt = (hdx & tx_busy) ? 1'b1 :
                           wrap_r[WRAP_EN] ? tx_line_r : rx_pin;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      brk_act_r <= 1'b0;
      tx_line_r <= 1'b1;
      rx_line_r <= 1'b1;
    end else begin
      brk_act_r <= brk_act_nxt;
      tx_line_r <= tx_line_nxt;
      rx_line_r <= rx_line_nxt;
    end
  end

  // ---------------------------------------------------------------
  // RS-485 direction
  // ---------------------------------------------------------------
  wire logic en485 = (pmode == PM_485) |
                     ((pmode == PM_485_ADDR) & match_r);
  wire logic [3:0] cnt_inc = 4'(cnt_r + 4'h1);

  always_comb begin
    dir_st_nxt = dir_st_r;
    unique case (dir_st_r)
      DS_IDLE: if (en485 & tx_busy) dir_st_nxt = DS_SEND;
      DS_SEND: begin
        if (!tx_busy) dir_st_nxt = (turn_r[3:0] == 4'h0) ? DS_IDLE : DS_HANG;
      end
      DS_HANG: begin
        if (tx_busy) dir_st_nxt = DS_SEND;
        else if (bit_tick && cnt_inc == turn_r[3:0]) dir_st_nxt = DS_IDLE;
      end
      default: dir_st_nxt = DS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dir_st_r <= DS_IDLE;
      cnt_r    <= 4'h0;
    end else begin
      dir_st_r <= p485 ? dir_st_nxt : DS_IDLE;
      cnt_r    <= (dir_st_r == DS_HANG && !tx_busy) ?
                  (bit_tick ? cnt_inc : cnt_r) : 4'h0;
    end
  end

  wire logic dir_act = dir_st_r != DS_IDLE;
  wire logic dir_nxt = func_r[FUNC_POL] ? dir_act : ~dir_act;

  // ---------------------------------------------------------------
  // General pins
  // ---------------------------------------------------------------
  wire logic [5:0] drv_nxt = (pin_drv_r | (wr_high ? wd[5:0] : 6'h00)) &
                             ~(wr_low ? wd[5:0] : 6'h00);
  wire logic [5:0] fn_oe  = (pmode == PM_DTRDSR) ? 6'h08 :
                            (pmode == PM_GPIO) ? 6'h00 : 6'h20;
  wire logic [5:0] fn_out = (pmode == PM_DTRDSR) ? {2'b00, rx_near_full, 3'b000} :
                            (pmode == PM_RTSCTS) ? {rx_near_full, 5'h00} :
                            p485 ? {dir_nxt, 5'h00} : 6'h00;
  wire logic [5:0] oe_nxt  = (dir_r & gen) | fn_oe;
  wire logic [5:0] out_nxt = (pin_drv_r & gen) | fn_out;
  wire logic [5:0] chg = (general_pin_in ^ prev_in_r) & mask_r &
                         ~dir_r & gen;
  wire logic [5:0] gi = general_pin_in;
  wire logic [7:0] hi_nxt = {1'b0, gi[5] & note_r[6], gi[4] & note_r[5],
                             gi[3] & note_r[4], gi[0] & note_r[3], 1'b0,
                             gi[2] & note_r[1], gi[1] & note_r[0]};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_drv_r    <= 6'h00;
      prev_in_r    <= 6'h00;
      gp_out_r     <= 6'h00;
      gp_oe_r      <= 6'h00;
      dir_out_r    <= 1'b1;
      note_pulse_r <= 1'b0;
      notify_hi_r  <= 8'h00;
    end else begin
      pin_drv_r    <= drv_nxt;
      prev_in_r    <= general_pin_in;
      gp_out_r     <= out_nxt;
      gp_oe_r      <= oe_nxt;
      dir_out_r    <= dir_nxt;
      note_pulse_r <= chg != 6'h00;
      notify_hi_r  <= hi_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Receive forwarding
  // ---------------------------------------------------------------
  wire logic [9:0] pkt = wide_r[PKT_63] ? PKT_CDC : PKT_FULL;
  wire logic fwd_nxt = bulk_in_req & (lat_r[LAT_EN] ? (rx_fifo_count != 10'h000) :
                       ((rx_fifo_count >= pkt) | idle_timeout));

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire logic [7:0] a = reg_req.addr;
  wire logic [7:0] rd_mux =
    hit(a, OFS_WIDE)  ? wide_r :
    hit(a, OFS_LAT)   ? lat_r :
    hit(a, OFS_NOTE)  ? note_r :
    hit(a, OFS_FLOW)  ? flow_r :
    hit(a, OFS_RES)   ? res_r :
    hit(a, OFS_PAUSE) ? pause_r :
    hit(a, OFS_WRAP)  ? wrap_r :
    hit(a, OFS_FAULT) ? {rx_break_live, flt_r, 3'b000} :
    hit(a, OFS_BRK)   ? brk_r :
    hit(a, OFS_TURN)  ? turn_r :
    hit(a, OFS_FUNC)  ? func_r :
    hit(a, OFS_DIR)   ? {2'b00, dir_r & gen} :
    hit(a, OFS_MASK)  ? {2'b00, mask_r} :
    hit(a, OFS_LVL)   ? {2'b00, general_pin_in & gen} : 8'h00;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
      fwd_r   <= 1'b0;
    end else begin
      rdata_r <= reg_req.rd ? rd_mux : 8'h00;
      fwd_r   <= fwd_nxt;
    end
  end

  assign reg_rdata               = rdata_r;
  assign general_pin_out         = gp_out_r;
  assign general_pin_oe          = gp_oe_r;
  assign line_direction_out      = dir_out_r;
  assign rx_line                 = rx_line_r;
  assign tx_line                 = tx_line_r;
  assign rx_keep                 = rx_keep_r;
  assign tx_hold                 = tx_hold_r;
  assign wide_mode               = wide_r[WIDE_EN];
  assign bulk_packet_size_select = wide_r[PKT_63];
  assign forward_now             = fwd_r;
  assign notify_pulse            = note_pulse_r;
  assign notify_hi               = notify_hi_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_pause_seen;
    swfc && rx_ev.valid && is_pause;
  endsequence
  sequence s_fault_read;
    rd_flt && flt_set == 4'h0 ##1 flt_set == 4'h0;
  endsequence

  chk_hdx_blank: assert property (hdx && tx_busy |=> rx_line)
    else $error("receive line not blanked in half duplex");
  chk_pause_tx: assert property (s_pause_seen |=> ##1 tx_hold)
    else $error("pause character did not hold transmitter");
  chk_wrap_route: assert property (wrap_r[WRAP_EN] && !(hdx && tx_busy)
    |=> rx_line == $past(tx_line))
    else $error("wrap path broken");
  chk_frame_sticky: assert property (rx_ev.valid && rx_ev.frame_err
    |=> flt_r[FLT_FRM-3] [*2] or (flt_r[FLT_FRM-3] ##1 $past(rd_flt)))
    else $error("framing flag lost");
  chk_fault_clear: assert property (s_fault_read |-> flt_r == 4'h0)
    else $error("fault read did not clear flags");
  chk_live_break: assert property (rd_flt |=>
    reg_rdata[FLT_LIVE] == $past(rx_break_live))
    else $error("live break bit wrong");
  chk_break_gap: assert property ($rose(brk_act_r) |-> $past(!tx_busy)
    ##1 !tx_line)
    else $error("break cut a character or line not low");
  chk_turn_hang: assert property (dir_st_r == DS_HANG && !tx_busy &&
    !bit_tick && p485 |=> dir_st_r == DS_HANG)
    else $error("direction released early");
  chk_pin_set: assert property (wr_high && wd[0] |=> pin_drv_r[0])
    else $error("drive high write ignored");
  chk_notify: assert property (chg != 6'h00 |=> notify_pulse)
    else $error("pin change not notified");
  chk_cdc_pkt: assert property (cdc_cmd |=> bulk_packet_size_select)
    else $error("class command did not select 63");
  chk_auto_lat: assert property (ll_auto |=> lat_r[LAT_EN])
    else $error("low latency not set for slow baud");
endmodule // uug_ctrl

// [rtl/uug_pkg.sv]
package uug_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_WIDE  = 8'h03;
  localparam logic [7:0] OFS_LAT   = 8'h04;
  localparam logic [7:0] OFS_NOTE  = 8'h06;
  localparam logic [7:0] OFS_FLOW  = 8'h08;
  localparam logic [7:0] OFS_RES   = 8'h09;
  localparam logic [7:0] OFS_PAUSE = 8'h0A;
  localparam logic [7:0] OFS_WRAP  = 8'h0B;
  localparam logic [7:0] OFS_FAULT = 8'h0C;
  localparam logic [7:0] OFS_BRK   = 8'h0D;
  localparam logic [7:0] OFS_TURN  = 8'h0E;
  localparam logic [7:0] OFS_FUNC  = 8'h0F;
  localparam logic [7:0] OFS_DIR   = 8'h10;
  localparam logic [7:0] OFS_MASK  = 8'h11;
  localparam logic [7:0] OFS_HIGH  = 8'h12;
  localparam logic [7:0] OFS_LOW   = 8'h13;
  localparam logic [7:0] OFS_LVL   = 8'h14;
  // ---------------------------------------------------------------
  // Writable bits and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_FLOW = 8'h0F;
  localparam logic [7:0] MASK_WRAP = 8'h04;
  localparam logic [7:0] MASK_TURN = 8'h0F;
  localparam logic [7:0] MASK_FUNC = 8'h0F;
  localparam logic [7:0] MASK_PIN  = 8'h3F;
  localparam logic [7:0] MASK_WIDE = 8'h03;
  localparam logic [7:0] MASK_LAT  = 8'h01;
  localparam logic [7:0] MASK_NOTE = 8'h7B;
  localparam logic [7:0] RST_REG   = 8'h00;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FLOW_HDX = 3;
  localparam int WRAP_EN  = 2;
  localparam int FLT_BRK  = 3;
  localparam int FLT_FRM  = 4;
  localparam int FLT_PAR  = 5;
  localparam int FLT_OVR  = 6;
  localparam int FLT_LIVE = 7;
  localparam int FUNC_POL = 3;
  localparam int WIDE_EN  = 0;
  localparam int PKT_63   = 1;
  localparam int LAT_EN   = 0;
  // ---------------------------------------------------------------
  // Counts and limits
  // ---------------------------------------------------------------
  localparam logic [9:0]  PKT_FULL      = 10'h040;
  localparam logic [9:0]  PKT_CDC       = 10'h03F;
  localparam logic [23:0] BAUD_LL_LIMIT = 24'h00B749;
  localparam logic [5:0]  GEN_ALL       = 6'h3F;
  localparam logic [5:0]  GEN_RTSCTS    = 6'h0F;
  localparam logic [5:0]  GEN_DTRDSR    = 6'h33;
  localparam logic [5:0]  GEN_485       = 6'h1F;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FM_NONE = 3'b000, FM_HW = 3'b001, FM_SW = 3'b010,
    FM_MD_RX = 3'b011, FM_MD_ALL = 3'b100
  } uug_flow_t;
  typedef enum logic [2:0] {
    PM_GPIO = 3'b000, PM_RTSCTS = 3'b001, PM_DTRDSR = 3'b010,
    PM_485 = 3'b011, PM_485_ADDR = 3'b100
  } uug_pin_t;
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00, DS_SEND = 2'b01, DS_HANG = 2'b10
  } uug_dir_st_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } uug_reg_req_t;
  typedef struct packed {
    logic       valid;
    logic       addr_flag;
    logic [7:0] data;
    logic       frame_err;
    logic       parity_err;
  } uug_rx_ev_t;
endpackage

// [verification/uug_far_model.sv]
`timescale 1ns/100ps
// ------------------
// Far-side sender
// ------------------
module uug_far_model (
  input  wire logic core_clk,
  input  wire logic send,
  input  wire logic tx_hold,
  output logic      tx_busy,
  output logic      bit_tick
);
  logic [3:0] cnt_r = 4'h0;
  initial tx_busy = 1'b0;
  initial bit_tick = 1'b0;
  // Starts only while not held, so a character is never cut short
  always @(posedge core_clk) begin
    bit_tick <= ~bit_tick;
    if (send && !tx_hold && !tx_busy) begin
      tx_busy <= 1'b1;
      cnt_r   <= 4'h8;
    end else if (tx_busy && bit_tick) begin
      cnt_r   <= cnt_r - 4'h1;
      tx_busy <= (cnt_r != 4'h1);
    end
  end
endmodule // uug_far_model

// [verification/testbench.sv]
`timescale 1ns/100ps
module testbench;
  import uug_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} uug_row_t;
  logic core_clk, resetn, tx_busy, bit_tick, send, rx_pin, full, brk, cdc, bload;
  logic rx_line, tx_line, tx_hold, dir_o, note, bulk, idle, keep, wide, pks, fwd;
  logic [9:0] cnt;
  logic [23:0] baud;
  logic [5:0] ext, gin, gout, goe;
  logic [7:0] rdata, nhi;
  uug_reg_req_t req;
  uug_rx_ev_t ev;
  int fail_count, checks, i, p, p0, k;
  uug_row_t rows [12];
  // Pin wire: driven level where enabled, outside level elsewhere
  assign gin = (goe & gout) | (~goe & ext);
  uug_ctrl dut_u (.core_clk(core_clk), .resetn(resetn), .reg_req(req), .reg_rdata(rdata),
    .rx_pin(rx_pin), .tx_shift(1'b1), .tx_busy(tx_busy), .bit_tick(bit_tick), .rx_ev(ev),
    .rx_fifo_full(full), .rx_near_full(1'b0), .rx_break_live(brk), .rx_fifo_count(cnt),
    .idle_timeout(idle), .bulk_in_req(bulk), .cdc_cmd(cdc), .baud_load(bload),
    .baud_rate(baud), .general_pin_in(gin), .general_pin_out(gout), .general_pin_oe(goe),
    .line_direction_out(dir_o), .rx_line(rx_line), .tx_line(tx_line), .rx_keep(keep),
    .tx_hold(tx_hold), .wide_mode(wide), .bulk_packet_size_select(pks), .forward_now(fwd),
    .notify_pulse(note), .notify_hi(nhi));
  uug_far_model far_u (.core_clk(core_clk), .send(send), .tx_hold(tx_hold),
    .tx_busy(tx_busy), .bit_tick(bit_tick));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, a, d};
    tick(1);
    req <= '0;
    tick(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    req <= '{1'b0, 1'b1, a, 8'h00};
    tick(1);
    req <= '0;
    #1 chk($sformatf("reg %h", a), rdata, e);
    tick(1);
  endtask
  // Character arrives; result settled two edges after it is taken
  task automatic rxc(input uug_rx_ev_t x, input logic f);
    ev <= x;
    full <= f;
    tick(1);
    ev <= '0;
    full <= 1'b0;
    tick(2);
    #1;
  endtask
  // Bulk-in request; forward decision stands for one cycle after it
  task automatic fwdc(input logic [9:0] c, input logic t, input logic [7:0] e);
    {cnt, idle, bulk} <= {c, t, 1'b1};
    tick(1);
    bulk <= 1'b0;
    #1 chk("forward", fwd, e);
    tick(1);
  endtask
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) if (note === 1'b1) p++;
  always @(posedge core_clk) if (keep === 1'b1) k++;
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #80000;
    fail_count++;
    test_done();
  end
  initial begin
    {resetn, send, rx_pin, full, brk, cdc, bload} = 7'h10;
    {baud, ext, req, ev, cnt, bulk, idle} = '0;
    {fail_count, checks, p, k} = '0;
    rows = '{'{OFS_WIDE, 8'hFF, 8'h03}, '{OFS_LAT, 8'hFF, 8'h01}, '{OFS_NOTE, 8'hFF, 8'h7B},
      '{OFS_FLOW, 8'hFF, 8'h0F}, '{OFS_RES, 8'hA5, 8'hA5}, '{OFS_PAUSE, 8'h5A, 8'h5A},
      '{OFS_WRAP, 8'hFF, 8'h04}, '{OFS_TURN, 8'hFF, 8'h0F}, '{OFS_FUNC, 8'hFF, 8'h0F},
      '{OFS_MASK, 8'hFF, 8'h3F}, '{OFS_HIGH, 8'hFF, 8'h00}, '{8'h20, 8'hFF, 8'h00}};
    tick(2);
    resetn <= 1'b1;
    tick(1);
    #1 chk("idle", {tx_line, rx_line, dir_o, tx_hold, note}, 8'h1C);
    tick(1);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
      wr(rows[i].a, 8'h00);
    end
    rxc('{1'b1, 1'b0, 8'h41, 1'b1, 1'b1}, 1'b1);
    tick(1);
    rdc(OFS_FAULT, 8'h70);
    rdc(OFS_FAULT, 8'h00);
    brk <= 1'b1;
    tick(2);
    rdc(OFS_FAULT, 8'h88);
    brk <= 1'b0;
    tick(2);
    rdc(OFS_FAULT, 8'h00);
    brk <= 1'b1;
    tick(1);
    brk <= 1'b0;
    tick(2);
    rdc(OFS_FAULT, 8'h08);
    wr(OFS_FLOW, 8'h02);
    wr(OFS_PAUSE, 8'h13);
    wr(OFS_RES, 8'h11);
    rxc('{1'b1, 1'b0, 8'h13, 1'b0, 1'b0}, 1'b0);
    chk("paused", tx_hold, 1);
    tick(1);
    rxc('{1'b1, 1'b0, 8'h11, 1'b0, 1'b0}, 1'b0);
    chk("resumed", tx_hold, 0);
    tick(1);
    wr(OFS_FLOW, 8'h04);
    rxc('{1'b1, 1'b1, 8'h11, 1'b0, 1'b0}, 1'b0);
    chk("matched", tx_hold, 0);
    rxc('{1'b1, 1'b0, 8'h55, 1'b0, 1'b0}, 1'b0);
    chk("kept", 8'(k), 8'h04);
    tick(1);
    wr(OFS_FLOW, 8'h00);
    wr(OFS_WRAP, 8'h04);
    wr(OFS_BRK, 8'h01);
    tick(4);
    #1 chk("break", {tx_hold, tx_line, rx_line}, 8'h04);
    tick(1);
    wr(OFS_BRK, 8'h00);
    wr(OFS_WRAP, 8'h00);
    wr(OFS_FUNC, 8'h0B);
    wr(OFS_TURN, 8'h02);
    wr(OFS_FLOW, 8'h08);
    #1 chk("dir idle", dir_o, 0);
    tick(1);
    send <= 1'b1;
    rx_pin <= 1'b0;
    tick(1);
    send <= 1'b0;
    tick(3);
    #1 chk("dir send", {dir_o, rx_line}, 8'h03);
    for (i = 0; i < 40 && tx_busy; i++) #4;
    chk("dir hang", {tx_busy, dir_o}, 8'h01);
    for (i = 0; i < 40 && dir_o; i++) #4;
    chk("dir release", 8'(i > 3 && i < 7), 1);
    tick(1);
    rx_pin <= 1'b1;
    wr(OFS_FUNC, 8'h00);
    wr(OFS_DIR, 8'h3F);
    wr(OFS_LOW, 8'h3F);
    wr(OFS_HIGH, 8'h05);
    wr(OFS_LOW, 8'h01);
    #1 chk("pins", {goe[1:0], gout}, 8'hC4);
    rdc(OFS_LVL, 8'h04);
    wr(OFS_DIR, 8'h00);
    wr(OFS_MASK, 8'h01);
    p0 = p;
    ext <= 6'h02;
    tick(4);
    ext <= 6'h03;
    tick(4);
    chk("notify", 8'(p - p0), 1);
    wr(OFS_NOTE, 8'h7B);
    #1 chk("notify hi", nhi, 8'h09);
    cdc <= 1'b1;
    tick(1);
    cdc <= 1'b0;
    rdc(OFS_WIDE, 8'h02);
    for (i = 0; i < 2; i++) begin
      baud <= 24'h00B749 - 24'(i);
      bload <= 1'b1;
      tick(1);
      bload <= 1'b0;
      rdc(OFS_LAT, 8'(i));
    end
    fwdc(10'h001, 1'b0, 8'h01);
    fwdc(10'h000, 1'b0, 8'h00);
    wr(OFS_LAT, 8'h00);
    fwdc(10'h03E, 1'b0, 8'h00);
    fwdc(10'h03F, 1'b0, 8'h01);
    fwdc(10'h001, 1'b1, 8'h01);
    wr(OFS_WIDE, 8'h01);
    fwdc(10'h03F, 1'b0, 8'h00);
    #1 chk("wide", {wide, pks}, 8'h02);
    wr(OFS_DIR, 8'h3F);
    wr(OFS_FUNC, 8'h01);
    wr(OFS_FLOW, 8'h01);
    ext <= 6'h10;
    tick(2);
    #1 chk("cts stop", {tx_hold, goe}, 8'h6F);
    rdc(OFS_DIR, 8'h0F);
    test_done();
  end
endmodule // testbench
